// ===== pll_ctrl_pkg.sv
/*
  Shared constants for the synthesizer control link: control word layout,
  reset word, result layout, timing figures and state encodings.
  Assumes a 100 MHz system clock on both ends.
*/
`default_nettype none
package pll_ctrl_pkg;
  localparam int WORD_BITS = 32;
  localparam int CNT_W = 6;
  localparam int COUNT_BITS = 20;
  localparam int UNLOCK_BITS = 4;
  localparam int RESULT_BITS = COUNT_BITS + UNLOCK_BITS;
  // Control word, shifted in bit 0 first
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 16;
  localparam int BAND_DIV_LSB = 4;
  localparam int CT_POS = 16;
  localparam int PORT_LSB = 17;
  localparam int PORT_W = 5;
  localparam int PL_POS = 22;
  localparam int PH_POS = 23;
  localparam int REF_LSB = 24;
  localparam int REF_W = 3;
  localparam int BAND_POS = 27;
  localparam int PS_POS = 28;
  localparam int IS_POS = 29;
  localparam int GT_POS = 30;
  localparam int TS_POS = 31;
  localparam logic [REF_W-1:0] REF_LOOP_OFF = 3'h7;
  localparam logic [WORD_BITS-1:0] RESET_WORD = 32'h0700_0000;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNLOCK_NS = 8000000;
  localparam int GATE_SHORT_NS = 8000000;
  localparam int GATE_LONG_NS = 16000000;
  localparam int ERR_STEP_NS = 1100;
  localparam int PULSE_MIN_NS = 1000;
  localparam int UNLOCK_CYC = UNLOCK_NS / CLK_PERIOD_NS;
  localparam int GATE_SHORT_CYC = GATE_SHORT_NS / CLK_PERIOD_NS;
  localparam int GATE_LONG_CYC = GATE_LONG_NS / CLK_PERIOD_NS;
  localparam int ERR_STEP_CYC = (ERR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_BIT_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;
  localparam int ERR_W = 10;
  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_UNLOCK = 4'b0010,
    M_GATE = 4'b0100,
    M_DONE = 4'b1000
  } meas_state_t;
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_SEND = 5'b00010,
    H_END = 5'b00100,
    H_WAIT = 5'b01000,
    H_READ = 5'b10000
  } host_state_t;
endpackage
`default_nettype wire

// ===== pll_link_if.sv
/*
  Three-wire control link plus the done/data return line.
  Host drives frame enable, shift clock and data; device drives done.
*/
`timescale 1ns/100ps
`default_nettype none
interface pll_link_if;
  logic frame_enable;
  logic serial_shift_clk;
  logic serial_input_line;
  logic done_flag;
  modport device(input frame_enable, input serial_shift_clk, input serial_input_line,
                 output done_flag);
  modport host(output frame_enable, output serial_shift_clk, output serial_input_line,
               input done_flag);
endinterface
`default_nettype wire

// ===== pll_synth_device.sv
/*
  Synthesizer control end: serial control word receiver, settings decode,
  IF frequency counter, unlock detector and done/result shifter.
  Assumes all link and pin inputs are asynchronous to sys_clk and change
  no faster than a few hundred ns.
*/
// Functional notes
// - Band set: division from bits four upward
// - Band clear: loaded value is half ratio
// - Band and swallow set: ratio direct binary
// - Count enable clear resets counter, pulls IF
// - Output port pins follow word bits
// - Pump bits force detector high, low, normal
// - Reference code selects rate or loop off
// - Loop off pulls local inputs, floats detector
// - Band bit selects FM or AM inputs
// - Swallow division only on AM input
// - Input choice bit selects input pin
// - Count enable: measure; gate bit picks time
// - Gate only: unlock detect; none: no data
// - Twenty-bit counter counts IF during gate
// - Result bit zero is least significant
// - Unlock detection runs eight milliseconds
// - Unlock detection ends before gate starts
// - Unlock detector idle when both bits clear
// - Error level thermometer in 1.1 us steps
// - Done line goes low on completion
// - Done line shifts result, rises on frame
// - Host loads test bit as zero
`timescale 1ns/100ps
`default_nettype none
module pll_synth_device #(
  parameter int UNLOCK_CYCLES = pll_ctrl_pkg::UNLOCK_CYC,
  parameter int GATE_SHORT_CYCLES = pll_ctrl_pkg::GATE_SHORT_CYC,
  parameter int GATE_LONG_CYCLES = pll_ctrl_pkg::GATE_LONG_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  pll_link_if.device link,
  input wire logic fm_intermediate_input,
  input wire logic am_intermediate_input,
  input wire logic [1:0] input_pins,
  input wire logic phase_error_in,
  input wire logic comparator_out,
  output logic [pll_ctrl_pkg::DIV_W-1:0] divider_value,
  output logic swallow_active,
  output logic am_select,
  output logic [pll_ctrl_pkg::REF_W-1:0] ref_freq_code,
  output logic loop_off,
  output logic fm_local_pulldown,
  output logic am_local_pulldown,
  output logic fm_if_pulldown,
  output logic am_if_pulldown,
  output logic phase_detector_out,
  output logic phase_detector_oe,
  output logic [pll_ctrl_pkg::PORT_W-1:0] output_port_bits,
  output logic input_port_value,
  output logic [pll_ctrl_pkg::COUNT_BITS-1:0] count_result,
  output logic [pll_ctrl_pkg::UNLOCK_BITS-1:0] unlock_error_level,
  output logic result_valid
);
  import pll_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0] ce_s;
    logic [2:0] ck_s;
    logic [1:0] da_s;
    logic [2:0] fm_s;
    logic [2:0] am_s;
    logic [1:0] err_s;
    logic [1:0] cmp_s;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [WORD_BITS-1:0] shift;
    logic [CNT_W-1:0] bitcnt;
    logic [WORD_BITS-1:0] word;
    meas_state_t mstate;
    logic [TIMER_W-1:0] timer;
    logic [COUNT_BITS-1:0] count;
    logic [ERR_W-1:0] err_run;
    logic [ERR_W-1:0] err_max;
    logic [RESULT_BITS-1:0] result_sr;
    logic done;
    logic [DIV_W-1:0] div;
    logic swallow;
    logic am_sel;
    logic [REF_W-1:0] ref_code;
    logic off;
    logic if_pull;
    logic pd_out;
    logic pd_oe;
    logic [PORT_W-1:0] ports;
    logic in_val;
    logic [COUNT_BITS-1:0] cnt_out;
    logic [UNLOCK_BITS-1:0] lvl_out;
    logic valid;
  } dev_state_t;

  localparam logic [ERR_W-1:0] STEP1 = ERR_W'(ERR_STEP_CYC);
  localparam logic [ERR_W-1:0] STEP2 = ERR_W'(2 * ERR_STEP_CYC);
  localparam logic [ERR_W-1:0] STEP3 = ERR_W'(3 * ERR_STEP_CYC);
  localparam logic [ERR_W-1:0] STEP4 = ERR_W'(4 * ERR_STEP_CYC);
  localparam logic [ERR_W-1:0] ERR_SAT = {ERR_W{1'b1}};

  dev_state_t st;
  dev_state_t next_st;
  logic ck_rise;
  logic ce_rise;
  logic ce_fall;
  logic if_edge;
  logic ct;
  logic gt;
  logic [UNLOCK_BITS-1:0] err_level;

  assign ck_rise = st.ck_s[1] & ~st.ck_s[2];
  assign ce_rise = st.ce_s[1] & ~st.ce_s[2];
  assign ce_fall = ~st.ce_s[1] & st.ce_s[2];
  assign ct = st.word[CT_POS];
  assign gt = st.word[GT_POS];
  // Band bit picks which IF pin is counted
  assign if_edge = st.am_sel ? (st.am_s[1] & ~st.am_s[2]) : (st.fm_s[1] & ~st.fm_s[2]);
  // Strictly longer than each step sets one more bit
  assign err_level = {st.err_max > STEP4, st.err_max > STEP3,
                      st.err_max > STEP2, st.err_max > STEP1};

  always_comb begin
    next_st = st;
    next_st.ce_s = {st.ce_s[1:0], link.frame_enable};
    next_st.ck_s = {st.ck_s[1:0], link.serial_shift_clk};
    next_st.da_s = {st.da_s[0], link.serial_input_line};
    next_st.fm_s = {st.fm_s[1:0], fm_intermediate_input};
    next_st.am_s = {st.am_s[1:0], am_intermediate_input};
    next_st.err_s = {st.err_s[0], phase_error_in};
    next_st.cmp_s = {st.cmp_s[0], comparator_out};
    next_st.pin_s1 = input_pins;
    next_st.pin_s2 = st.pin_s1;

    // Receive: bit 0 first, shifted on clock rise inside the frame
    if (ce_rise) begin
      next_st.bitcnt = '0;
      next_st.done = 1'b1;
    end else if (st.ce_s[1] && ck_rise) begin
      next_st.shift = {st.da_s[1], st.shift[WORD_BITS-1:1]};
      if (st.bitcnt != CNT_W'(WORD_BITS)) begin
        next_st.bitcnt = st.bitcnt + 1'b1;
      end
    end

    // Measurement sequencer
    unique case (st.mstate)
      M_IDLE: begin
      end
      M_UNLOCK: begin
        // Track the widest error pulse seen in the window
        if (st.err_s[1]) begin
          if (st.err_run != ERR_SAT) begin
            next_st.err_run = st.err_run + 1'b1;
          end
        end else begin
          next_st.err_run = '0;
        end
        if (st.err_run > st.err_max) begin
          next_st.err_max = st.err_run;
        end
        if (st.timer == '0) begin
          // Unlock window closes before the gate opens
          if (ct) begin
            next_st.mstate = M_GATE;
            next_st.timer = gt ? TIMER_W'(GATE_LONG_CYCLES - 1)
                               : TIMER_W'(GATE_SHORT_CYCLES - 1);
          end else begin
            next_st.mstate = M_DONE;
          end
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
      M_GATE: begin
        if (if_edge) begin
          next_st.count = st.count + 1'b1;
        end
        if (st.timer == '0) begin
          next_st.mstate = M_DONE;
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
      M_DONE: begin
      end
    endcase

    // Completion: drop done, load result, bit 0 goes out first
    if (st.mstate != M_DONE && next_st.mstate == M_DONE) begin
      next_st.done = 1'b0;
      next_st.result_sr = {err_level, st.count};
      next_st.cnt_out = st.count;
      next_st.lvl_out = err_level;
      next_st.valid = 1'b1;
    end else if (st.mstate == M_DONE && !st.ce_s[1] && ck_rise) begin
      // Each clock rise outside a frame presents the next result bit
      next_st.done = st.result_sr[0];
      next_st.result_sr = {1'b0, st.result_sr[RESULT_BITS-1:1]};
    end

    // Only a whole word is applied, all fields at once
    if (ce_fall && st.bitcnt == CNT_W'(WORD_BITS)) begin
      next_st.word = st.shift;
      next_st.err_run = '0;
      next_st.err_max = '0;
      next_st.count = '0;
      next_st.valid = 1'b0;
      next_st.timer = TIMER_W'(UNLOCK_CYCLES - 1);
      if (st.shift[CT_POS] || st.shift[GT_POS]) begin
        next_st.mstate = M_UNLOCK;
      end else begin
        next_st.mstate = M_IDLE;
      end
    end

    // Count enable clear holds the counter at zero
    if (!ct) begin
      next_st.count = '0;
    end

    // Settings decode, registered so outputs come from flops
    // Swallow mode on the AM side takes all sixteen bits as the ratio
    next_st.div = (st.word[BAND_POS] && !st.word[PS_POS])
                  ? {{BAND_DIV_LSB{1'b0}}, st.word[DIV_W-1:BAND_DIV_LSB]}
                  : st.word[DIV_LSB +: DIV_W];
    next_st.am_sel = st.word[BAND_POS];
    next_st.swallow = st.word[BAND_POS] & st.word[PS_POS];
    next_st.ref_code = st.word[REF_LSB +: REF_W];
    next_st.off = (st.word[REF_LSB +: REF_W] == REF_LOOP_OFF);
    next_st.if_pull = ~ct;
    next_st.ports = st.word[PORT_LSB +: PORT_W];
    next_st.in_val = st.word[IS_POS] ? st.pin_s2[1] : st.pin_s2[0];
    if (next_st.off) begin
      next_st.pd_oe = 1'b0;
      next_st.pd_out = 1'b0;
    end else begin
      next_st.pd_oe = 1'b1;
      unique case ({st.word[PH_POS], st.word[PL_POS]})
        2'b00: next_st.pd_out = st.cmp_s[1];
        2'b10: next_st.pd_out = 1'b1;
        default: next_st.pd_out = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.mstate <= M_IDLE;
      st.word <= RESET_WORD;
      st.ref_code <= REF_LOOP_OFF;
      st.off <= 1'b1;
      st.if_pull <= 1'b1;
      st.done <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.done_flag = st.done;
  assign divider_value = st.div;
  assign swallow_active = st.swallow;
  assign am_select = st.am_sel;
  assign ref_freq_code = st.ref_code;
  assign loop_off = st.off;
  // Pulldown of both local inputs tracks loop off
  assign fm_local_pulldown = st.off;
  assign am_local_pulldown = st.off;
  assign fm_if_pulldown = st.if_pull;
  assign am_if_pulldown = st.if_pull;
  assign phase_detector_out = st.pd_out;
  assign phase_detector_oe = st.pd_oe;
  assign output_port_bits = st.ports;
  assign input_port_value = st.in_val;
  assign count_result = st.cnt_out;
  assign unlock_error_level = st.lvl_out;
  assign result_valid = st.valid;
endmodule
`default_nettype wire

// ===== pll_synth_host.sv
/*
  Host end of the control link: builds and sends the 32-bit control word,
  then, when a measurement was asked for, waits for done and reads the
  24-bit result. Makes the shift clock itself from sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pll_synth_host #(
  parameter int HALF_CYCLES = pll_ctrl_pkg::HALF_BIT_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  pll_link_if.host link,
  input wire logic start,
  input wire logic [pll_ctrl_pkg::DIV_W-1:0] division_ratio,
  input wire logic [pll_ctrl_pkg::WORD_BITS-1:pll_ctrl_pkg::DIV_W] settings,
  output logic busy,
  output logic result_valid,
  output logic [pll_ctrl_pkg::COUNT_BITS-1:0] count_result,
  output logic [pll_ctrl_pkg::UNLOCK_BITS-1:0] unlock_error_level
);
  import pll_ctrl_pkg::*;

  typedef struct packed {
    host_state_t hstate;
    logic [15:0] div_cnt;
    logic [WORD_BITS-1:0] tx;
    logic [RESULT_BITS-1:0] rx;
    logic [CNT_W-1:0] bitcnt;
    logic read_back;
    logic [1:0] done_s;
    logic ce;
    logic ck;
    logic da;
    logic busy;
    logic valid;
  } host_state_struct_t;

  host_state_struct_t st;
  host_state_struct_t next_st;
  logic tick;
  logic [WORD_BITS-1:0] word;

  assign tick = (st.div_cnt == 16'(HALF_CYCLES - 1));

  always_comb begin
    word = {settings, division_ratio};
    word[TS_POS] = 1'b0;
    // Band clear: send half the ratio; band set: send it as given
    if (!settings[BAND_POS]) begin
      word[DIV_LSB +: DIV_W] = {1'b0, division_ratio[DIV_W-1:1]};
    end
  end

  always_comb begin
    next_st = st;
    next_st.done_s = {st.done_s[0], link.done_flag};
    next_st.div_cnt = (tick || st.hstate == H_IDLE) ? '0 : st.div_cnt + 1'b1;
    unique case (st.hstate)
      H_IDLE: begin
        if (start) begin
          next_st.hstate = H_SEND;
          next_st.tx = word;
          next_st.da = word[0];
          next_st.read_back = word[CT_POS] | word[GT_POS];
          next_st.ce = 1'b1;
          next_st.ck = 1'b0;
          next_st.bitcnt = '0;
          next_st.busy = 1'b1;
          next_st.valid = 1'b0;
        end
      end
      H_SEND: begin
        if (tick) begin
          if (!st.ck) begin
            next_st.ck = 1'b1;
          end else begin
            // Data changes only while the clock is low
            next_st.ck = 1'b0;
            next_st.tx = {1'b0, st.tx[WORD_BITS-1:1]};
            next_st.da = st.tx[1];
            next_st.bitcnt = st.bitcnt + 1'b1;
            if (st.bitcnt == CNT_W'(WORD_BITS - 1)) begin
              next_st.hstate = H_END;
            end
          end
        end
      end
      H_END: begin
        if (tick) begin
          next_st.ce = 1'b0;
          next_st.da = 1'b0;
          next_st.bitcnt = '0;
          next_st.hstate = st.read_back ? H_WAIT : H_IDLE;
          next_st.busy = st.read_back;
        end
      end
      H_WAIT: begin
        // Low done marks the finished measurement
        if (!st.done_s[1] && tick) begin
          next_st.hstate = H_READ;
        end
      end
      H_READ: begin
        if (tick) begin
          if (!st.ck) begin
            next_st.ck = 1'b1;
          end else begin
            // Sample a half bit after the rise that moved the data
            next_st.ck = 1'b0;
            next_st.rx = {st.done_s[1], st.rx[RESULT_BITS-1:1]};
            next_st.bitcnt = st.bitcnt + 1'b1;
            if (st.bitcnt == CNT_W'(RESULT_BITS - 1)) begin
              next_st.hstate = H_IDLE;
              next_st.busy = 1'b0;
              next_st.valid = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.hstate <= H_IDLE;
      st.done_s <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign link.frame_enable = st.ce;
  assign link.serial_shift_clk = st.ck;
  assign link.serial_input_line = st.da;
  assign busy = st.busy;
  assign result_valid = st.valid;
  assign count_result = st.rx[COUNT_BITS-1:0];
  assign unlock_error_level = st.rx[RESULT_BITS-1:COUNT_BITS];
endmodule
`default_nettype wire

// ===== pll_link_checker.sv
/*
  Checker for the control link between host and synthesizer ends.
  Assumes it watches the interface signals in the sys_clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module pll_link_checker #(
  parameter int HALF_CYCLES = pll_ctrl_pkg::HALF_BIT_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic frame_enable,
  input wire logic serial_shift_clk,
  input wire logic serial_input_line,
  input wire logic done_flag
);
  import pll_ctrl_pkg::*;
  logic prev_ck;
  logic [7:0] bit_cnt;
  logic [15:0] hi_cnt;
  // Counters let the frame length and clock width be checked without long repeats
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_ck <= 1'b0;
      bit_cnt <= '0;
      hi_cnt <= '0;
    end else begin
      prev_ck <= serial_shift_clk;
      if (!frame_enable) bit_cnt <= '0;
      else if (serial_shift_clk && !prev_ck) bit_cnt <= bit_cnt + 8'h01;
      hi_cnt <= serial_shift_clk ? hi_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_done_rise_frame: assert property ($rose(frame_enable) |-> ##[1:6] done_flag)
    else $error("done line did not rise after frame start");
  chk_done_high_frame: assert property (frame_enable && $past(frame_enable, 6) |-> done_flag)
    else $error("done line low inside a frame");
  chk_done_fall_idle: assert property ($fell(done_flag) |-> !frame_enable)
    else $error("done line fell during a frame");
  chk_hold_after_frame: assert property ($fell(frame_enable) |-> done_flag [*8])
    else $error("done line fell too soon after a frame");
  chk_word_length: assert property ($fell(frame_enable) |-> bit_cnt == WORD_BITS)
    else $error("frame did not carry a full word");
  chk_clk_half_width: assert property ($fell(serial_shift_clk) |-> hi_cnt == HALF_CYCLES)
    else $error("shift clock high time wrong");
  chk_data_stable_high: assert property (serial_shift_clk && $past(serial_shift_clk) && frame_enable
    |-> $stable(serial_input_line))
    else $error("data changed while shift clock high");
  chk_clk_low_edges: assert property ($rose(frame_enable) || $fell(frame_enable)
    |-> !serial_shift_clk)
    else $error("shift clock high at a frame edge");
  chk_test_bit_zero: assert property ($rose(serial_shift_clk) && frame_enable && bit_cnt == 8'd31
    |-> !serial_input_line)
    else $error("last word bit not zero");
  cov_frame_end: cover property ($fell(frame_enable));
  cov_done_low: cover property ($fell(done_flag) && !serial_shift_clk);
  cov_read_clock: cover property ($rose(serial_shift_clk) && !frame_enable);
endmodule
`default_nettype wire

// ===== pll_synth_control_and_freq_counter_tb.sv
/*
  Testbench: host end drives the device end over the link interface.
  Assumes shortened unlock and gate counts and an 8-cycle shift half period.
*/
`timescale 1ns/100ps
`default_nettype none
module pll_synth_control_and_freq_counter_tb;
  import pll_ctrl_pkg::*;
  typedef struct packed {
    logic [15:0] div;
    logic [2:0] rf;
    logic [4:0] port;
    logic [19:0] cnt;
    logic [3:0] lvl;
    logic [10:0] f;
  } exp_t;
  logic sys_clk, arst_n, start, fm_if, am_if, perr, cmp;
  logic [1:0] pins;
  logic [15:0] ratio, settings, d_div;
  logic h_busy, h_val, d_val, d_sw, d_am, d_off, d_fpd, d_apd, d_fif, d_aif, d_pd, d_oe, d_in;
  logic [2:0] d_rf;
  logic [4:0] d_port;
  logic [19:0] h_cnt, d_cnt;
  logic [3:0] h_lvl, d_lvl;
  int error_cnt, total_checks, seed;
  exp_t q[$];
  pll_link_if link();
  pll_synth_device #(.UNLOCK_CYCLES(600), .GATE_SHORT_CYCLES(300), .GATE_LONG_CYCLES(600))
    u_pll_synth_device (.sys_clk(sys_clk), .arst_n(arst_n), .link(link),
    .fm_intermediate_input(fm_if), .am_intermediate_input(am_if), .input_pins(pins),
    .phase_error_in(perr), .comparator_out(cmp), .divider_value(d_div),
    .swallow_active(d_sw), .am_select(d_am), .ref_freq_code(d_rf), .loop_off(d_off),
    .fm_local_pulldown(d_fpd), .am_local_pulldown(d_apd), .fm_if_pulldown(d_fif),
    .am_if_pulldown(d_aif), .phase_detector_out(d_pd), .phase_detector_oe(d_oe),
    .output_port_bits(d_port), .input_port_value(d_in), .count_result(d_cnt),
    .unlock_error_level(d_lvl), .result_valid(d_val));
  pll_synth_host #(.HALF_CYCLES(8)) u_pll_synth_host (.sys_clk(sys_clk), .arst_n(arst_n),
    .link(link), .start(start), .division_ratio(ratio), .settings(settings),
    .busy(h_busy), .result_valid(h_val), .count_result(h_cnt), .unlock_error_level(h_lvl));
  pll_link_checker #(.HALF_CYCLES(8)) u_pll_link_checker (.sys_clk(sys_clk),
    .arst_n(arst_n), .frame_enable(link.frame_enable),
    .serial_shift_clk(link.serial_shift_clk), .serial_input_line(link.serial_input_line),
    .done_flag(link.done_flag));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // s holds word bits 31:16; index i walks every code of ref, pump and count/gate
  task automatic run_one(input int i);
    exp_t e;
    logic [15:0] s, r;
    logic m, pv, off;
    int len;
    s = $random(seed);
    r = $random(seed);
    s[0] = i[1];
    s[14] = i[0];
    s[7:6] = i[2:1];
    s[10:8] = i[2:0];
    s[15] = 1'b0;
    // Band and swallow are walked so that every division mode is reached
    s[11] = i[0] ^ i[2];
    s[12] = i[0] ^ i[1];
    if (s[11] && !s[12]) e.div = {4'h0, r[15:4]};
    else if (s[11]) e.div = r;
    else begin
      r[0] = 1'b0;
      e.div = {1'b0, r[15:1]};
    end
    pins = $random(seed);
    cmp = $random(seed);
    len = 60 + 110 * (($random(seed) & 32'h7fffffff) % 5);
    m = s[0] | s[14];
    off = (s[10:8] == 3'h7);
    pv = (s[7] & ~s[6]) ? 1'b1 : ((s[7] | s[6]) ? 1'b0 : cmp);
    e.rf = s[10:8];
    e.port = s[5:1];
    e.cnt = s[0] ? 20'h00014 : 20'h00000;
    for (int k = 0; k < 4; k++) e.lvl[k] = m && (len > (k + 1) * 110);
    e.f = {s[11] & s[12], s[11], off, off, off, ~s[0], ~s[0], pv & ~off, ~off,
           s[13] ? pins[1] : pins[0], m};
    q.push_back(e);
    ratio = r;
    settings = s;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    @(negedge link.frame_enable);
    tick(45);
    perr = 1'b1;
    tick(len);
    perr = 1'b0;
    tick(600 - len);
    // Unselected IF input also toggles, so a wrong input choice shows in the count
    for (int k = 0; k < 20; k++) begin
      fm_if = s[11] ? (k < 7) : 1'b1;
      am_if = s[11] ? 1'b1 : (k < 7);
      tick(5);
      fm_if = 1'b0;
      am_if = 1'b0;
      tick(5);
    end
    for (int w = 0; w < 5000 && h_busy; w++) tick(1);
    tick(12);
  endtask
  initial begin
    exp_t e;
    wait (arst_n === 1'b1);
    forever begin
      @(negedge h_busy);
      tick(8);
      e = q.pop_front();
      chk(d_div, e.div);
      chk(d_rf, e.rf);
      chk(d_port, e.port);
      chk({d_sw, d_am, d_off, d_fpd, d_apd, d_fif, d_aif, d_pd & ~e.f[8], d_oe, d_in, d_val},
          e.f);
      if (e.f[0]) begin
        chk({h_val, h_cnt, h_lvl}, {1'b1, e.cnt, e.lvl});
        chk({d_cnt, d_lvl}, {e.cnt, e.lvl});
      end
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    seed = 20501;
    arst_n = 1'b0;
    {start, fm_if, am_if, perr, cmp, pins, ratio, settings} = '0;
    tick(6);
    arst_n = 1'b1;
    tick(1);
    for (int i = 0; i < 8; i++) run_one(i);
    // A note never taken off the queue means a transfer that never ended
    chk(q.size(), 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
